/* File: tb/pmx_far_model.sv */
// Far-side model: the memories, bus masters and DMA peers that share the pins
`timescale 1ns/10ps
`default_nettype none
module pmx_far_model (
  // Clock
  input wire logic clk,
  // Pin drive from the block
  input wire logic [11:0] pin_out,
  input wire logic [11:0] pin_oe,
  // Far-side drive, chosen by the bench
  input wire logic [11:0] ext_drive,
  input wire logic [11:0] ext_level,
  // Resolved wire levels
  output logic [11:0] pin_in
);
  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  logic [11:0] float_q = 12'h000; // Undriven pins wander every cycle

  // A pin nobody drives must not keep its last level, so it toggles
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Block drive wins; a capture pin then reads the port's own level
  // A master wanting the bus drives the request pin high
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_drive[i]) begin
        pin_in[i] = ext_level[i];
      end else begin
        pin_in[i] = float_q[i];
      end
    end
  end
endmodule : pmx_far_model
`default_nettype wire

/* File: tb/pmx_mux_tb.sv */
// Self-checking bench for the shared-pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module pmx_mux_tb;
  // ------------------------------------------------------------
  // Stimulus and observation
  // ------------------------------------------------------------
  logic clk;
  logic nrst;
  logic [8:0] en; // ack,end,stop,fly_wr,fly_rd,ready,grant,request,bus mode
  logic [9:0] per; // ack,end,fly_wr,fly_rd,cs0..cs3,released,read strobe
  logic [3:1] cs_en;
  logic [2:0] cap_sel;
  logic [11:0] port_out, port_dir, ext_drive, ext_level;
  wire logic [11:0] pin_in, pin_out, pin_oe, port_in;
  wire logic stop_in, ready_in, request_in, cap0, cap1, cap2;
  wire logic [11:0] ins_seen = {6'h00, stop_in, ready_in, request_in, cap2, cap1, cap0};
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  pmx_mux #(.N(12)) dut (
    .clk(clk), .nrst(nrst), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .dma_ack_out_1(per[9]), .dma_end_out_1(per[8]), .flyby_write_strobe(per[7]),
    .flyby_read_strobe(per[6]), .chip_sel_0(per[5]), .chip_sel_1(per[4]),
    .chip_sel_2(per[3]), .chip_sel_3(per[2]), .bus_released(per[1]),
    .bus_read_strobe(per[0]), .ack_en(en[8]), .end_en(en[7]), .stop_en(en[6]),
    .fly_wr_en(en[5]), .fly_rd_en(en[4]), .chip_sel_en(cs_en), .ready_en(en[3]),
    .grant_en(en[2]), .request_en(en[1]), .ext_bus_mode(en[0]), .capture_sel(cap_sel),
    .port_out(port_out), .port_dir(port_dir), .port_in(port_in),
    .dma_stop_in_1(stop_in), .bus_ready_in(ready_in), .bus_request_in(request_in),
    .capture_input_0(cap0), .capture_input_1(cap1), .capture_input_2(cap2)
  );

  pmx_far_model far (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive),
    .ext_level(ext_level), .pin_in(pin_in)
  );

  // 125 MHz clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Let the input path settle, then compare every pin and input to the reference
  task automatic check_all();
    logic [11:0] role, pv, mask, eoe, eout, wl, eins;
    repeat (4) @(posedge clk);
    @(negedge clk);
    role = {en[0], en[1], en[2], en[3], cs_en[3], cs_en[2], cs_en[1], en[0],
            en[4], en[5], en[7] | en[6], en[8]};
    pv = {per[0], 1'h0, ~per[1], 1'h0, per[2], per[3], per[4], per[5],
          per[6], per[7], per[8], per[9]};
    // Ready and request pins are released in peripheral role; end/stop only drives for end
    mask = {4'ha, 6'h3f, en[7], 1'h1};
    eoe = (role & mask) | (~role & port_dir);
    eout = (role & pv) | (~role & port_out);
    wl = (eoe & eout) | (~eoe & ext_level);
    eins = {6'h00, en[6] ? wl[1] : 1'h1, en[3] ? wl[8] : 1'h1,
            en[1] ? wl[10] : 1'h0, wl[10:8] & cap_sel};
    check("pin_oe", pin_oe, eoe);
    check("pin_out", pin_out & eoe, eout & eoe);
    check("port_in", port_in, wl);
    check("inputs", ins_seen, eins);
  endtask : check_all

  // Counts, verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Hang guard: the sequence needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'h0;
    en = '0;
    per = '0;
    cs_en = '0;
    cap_sel = '0;
    port_out = '0;
    port_dir = '0;
    ext_drive = '0;
    ext_level = '0;
    repeat (7) @(posedge clk);
    @(negedge clk);
    check("rst_pin_oe", pin_oe, 12'h000);
    check("rst_inputs", ins_seen, 12'h030);
    @(posedge clk);
    nrst <= 1'h1;
    ext_drive <= 12'hfff;
    // Every pin in port role, port driving
    port_dir <= 12'hfff;
    port_out <= 12'ha5a;
    check_all();
    // Port as input, far side drives
    @(posedge clk);
    port_dir <= 12'h000;
    port_out <= 12'h5a5;
    ext_level <= 12'hc3c;
    check_all();
    // All functions on; port settings must be ignored
    @(posedge clk);
    en <= 9'h1ff;
    cs_en <= 3'h7;
    per <= 10'h2b5;
    port_dir <= 12'hfff;
    port_out <= 12'h0f0;
    ext_level <= 12'h000;
    check_all();
    @(posedge clk);
    per <= 10'h14a;
    ext_level <= 12'hfff;
    check_all();
    // Acceptance off: pin follows port exactly one cycle later
    @(posedge clk);
    en[8] <= 1'h0;
    port_dir[0] <= 1'h0;
    @(negedge clk);
    check("ack_hold", pin_oe & 12'h001, 12'h001);
    @(posedge clk);
    @(negedge clk);
    check("ack_drop", pin_oe & 12'h001, 12'h000);
    // Stop input alone: pin released, stop reads the wire
    @(posedge clk);
    en <= 9'h040;
    ext_level <= 12'h000;
    check_all();
    // Chip select enables in every combination, bus mode following the chip select 1 enable
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      cs_en <= 3'(i);
      en <= {8'h00, 1'(i)};
      check_all();
    end
    // Bus request honoured, then grant with the bus released
    @(posedge clk);
    en <= 9'h002;
    ext_level <= 12'h400;
    check_all();
    @(posedge clk);
    en <= 9'h004;
    per <= 10'h002;
    check_all();
    // Capture selections, with the port still driving one capture pin
    @(posedge clk);
    en <= 9'h000;
    port_dir <= 12'h200;
    port_out <= 12'h200;
    ext_level <= 12'h500;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      cap_sel <= 3'(i);
      check_all();
    end
    // Reset in mid-run: pins float again, inputs go idle, then all recovers
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("mid_rst_pin_oe", pin_oe, 12'h000);
    check("mid_rst_inputs", ins_seen, 12'h030);
    @(posedge clk);
    nrst <= 1'h1;
    check_all();
    complete_run();
  end
endmodule : pmx_mux_tb
`default_nettype wire

/* File: verilog/pmx_drive.sv */
// Output register stage that holds the level and drive of every pin
`timescale 1ns/10ps
`default_nettype none
module pmx_drive #(
  parameter int N = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Selection from the core
  pmx_drv_if.drv drv
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] out;  // Pin level
    logic [N-1:0] oe;   // Pin drive, high while driving
  } pmx_drive_t;

  pmx_drive_t st;
  pmx_drive_t next_st;

  // Take the selection; pins float after reset so nothing fights
  always_comb begin
    next_st.out = drv.sel_out;
    next_st.oe = drv.sel_oe;
    if (!nrst) begin
      next_st.out = pmx_pkg::RST_PIN_OUT[N-1:0];
      next_st.oe = pmx_pkg::RST_PIN_OE[N-1:0];
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign drv.pin_out = st.out;
  assign drv.pin_oe = st.oe;

endmodule : pmx_drive
`default_nettype wire

/* File: verilog/pmx_drv_if.sv */
// Selected pin levels passed from the mux core to the pin driver
`timescale 1ns/10ps
`default_nettype none
interface pmx_drv_if #(parameter int N = 12);
  logic [N-1:0] sel_out;  // Level chosen for each pin
  logic [N-1:0] sel_oe;   // Drive chosen for each pin
  logic [N-1:0] pin_out;  // Registered level on the pins
  logic [N-1:0] pin_oe;   // Registered drive on the pins
  modport src (output sel_out, output sel_oe, input pin_out, input pin_oe);
  modport drv (input sel_out, input sel_oe, output pin_out, output pin_oe);
endinterface : pmx_drv_if
`default_nettype wire

/* File: verilog/pmx_mux.sv */
// Shared-pin multiplexer for DMA channel 1, chip selects and bus control
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Acceptance pin: ack when enabled, else port
// - End/stop pin drives end when enabled
// - End/stop pin feeds stop when enabled
// - End/stop pin is port only if both off
// - Fly-by write pin: strobe or port
// - Fly-by read pin: strobe or port
// - Chip select 0 in bus mode, else port
// - Chip selects 1-3 per own enable, else port
// - Ready pin feeds ready when enabled, else port
// - Grant pin low while bus released
// - Grant pin is port when disabled
// - Request pin is port when disabled
// - Read strobe in bus mode, else port
// - Capture inputs sample pins whenever selected
module pmx_mux #(
  parameter int N = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Shared pins
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe,
  // Peripheral outputs
  input wire logic dma_ack_out_1,
  input wire logic dma_end_out_1,
  input wire logic flyby_write_strobe,
  input wire logic flyby_read_strobe,
  input wire logic chip_sel_0,
  input wire logic chip_sel_1,
  input wire logic chip_sel_2,
  input wire logic chip_sel_3,
  input wire logic bus_released,
  input wire logic bus_read_strobe,
  // Function enables and mode
  input wire logic ack_en,
  input wire logic end_en,
  input wire logic stop_en,
  input wire logic fly_wr_en,
  input wire logic fly_rd_en,
  input wire logic [3:1] chip_sel_en,
  input wire logic ready_en,
  input wire logic grant_en,
  input wire logic request_en,
  input wire logic ext_bus_mode,
  input wire logic [2:0] capture_sel,
  // General-purpose port
  input wire logic [N-1:0] port_out,
  input wire logic [N-1:0] port_dir,
  output logic [N-1:0] port_in,
  // Inputs delivered to peripherals
  output logic dma_stop_in_1,
  output logic bus_ready_in,
  output logic bus_request_in,
  output logic capture_input_0,
  output logic capture_input_1,
  output logic capture_input_2
);

  // ----------------------------------------------------------------
  // Pin input synchroniser and output driver
  // ----------------------------------------------------------------
  logic [N-1:0] pin_sync;  // Pin levels after two flops

  pmx_drv_if #(.N(N)) drv_if ();

  pmx_sync #(.N(N)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  pmx_drive #(.N(N)) u_drive (
    .clk(clk),
    .nrst(nrst),
    .drv(drv_if.drv)
  );

  assign pin_out = drv_if.pin_out;
  assign pin_oe = drv_if.pin_oe;

  // ----------------------------------------------------------------
  // Output selection per pin
  // ----------------------------------------------------------------
  logic [N-1:0] func_sel;  // Pin in its peripheral role
  logic [N-1:0] func_out;  // Peripheral level per pin
  logic [N-1:0] func_oe;   // Peripheral drive per pin

  // Decide each pin's role from the enables and the chip mode
  always_comb begin
    func_sel = '0;
    func_out = '0;
    func_oe = '0;
    func_sel[pmx_pkg::PIN_ACK] = ack_en;
    func_out[pmx_pkg::PIN_ACK] = dma_ack_out_1;
    func_oe[pmx_pkg::PIN_ACK] = 1'h1;
    // Stop alone leaves the pin undriven so the far side can pull it
    func_sel[pmx_pkg::PIN_END_STOP] = end_en | stop_en;
    func_out[pmx_pkg::PIN_END_STOP] = dma_end_out_1;
    func_oe[pmx_pkg::PIN_END_STOP] = end_en;
    func_sel[pmx_pkg::PIN_FLY_WR] = fly_wr_en;
    func_out[pmx_pkg::PIN_FLY_WR] = flyby_write_strobe;
    func_oe[pmx_pkg::PIN_FLY_WR] = 1'h1;
    func_sel[pmx_pkg::PIN_FLY_RD] = fly_rd_en;
    func_out[pmx_pkg::PIN_FLY_RD] = flyby_read_strobe;
    func_oe[pmx_pkg::PIN_FLY_RD] = 1'h1;
    func_sel[pmx_pkg::PIN_CS0] = ext_bus_mode;
    func_out[pmx_pkg::PIN_CS0] = chip_sel_0;
    func_oe[pmx_pkg::PIN_CS0] = 1'h1;
    func_sel[pmx_pkg::PIN_CS3:pmx_pkg::PIN_CS1] = chip_sel_en;
    func_out[pmx_pkg::PIN_CS3:pmx_pkg::PIN_CS1] = {chip_sel_3, chip_sel_2, chip_sel_1};
    func_oe[pmx_pkg::PIN_CS3:pmx_pkg::PIN_CS1] = 3'h7;
    // Ready is input only; the pin is released while enabled
    func_sel[pmx_pkg::PIN_READY] = ready_en;
    func_sel[pmx_pkg::PIN_GRANT] = grant_en;
    func_out[pmx_pkg::PIN_GRANT] = bus_released ? pmx_pkg::GRANT_ACTIVE
                                                : ~pmx_pkg::GRANT_ACTIVE;
    func_oe[pmx_pkg::PIN_GRANT] = 1'h1;
    func_sel[pmx_pkg::PIN_REQUEST] = request_en;
    func_sel[pmx_pkg::PIN_READ] = ext_bus_mode;
    func_out[pmx_pkg::PIN_READ] = bus_read_strobe;
    func_oe[pmx_pkg::PIN_READ] = 1'h1;
  end

  // Port bits take over any pin not in its peripheral role
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      assign drv_if.sel_out[g] = func_sel[g] ? func_out[g] : port_out[g];
      assign drv_if.sel_oe[g] = func_sel[g] ? func_oe[g] : port_dir[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Inputs delivered to peripherals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] port_in;   // Port read-back, the wire level in every role; zero in reset
    logic stop;
    logic ready;
    logic request;
    logic [2:0] capture;
    logic [1:0] age;         // Cycles since reset, saturating at 3
  } pmx_mux_t;

  pmx_mux_t st;
  pmx_mux_t next_st;

  // Route synchronised pin levels; disabled inputs sit at idle
  always_comb begin
    next_st = st;
    next_st.port_in = pin_sync;
    next_st.stop = stop_en ? pin_sync[pmx_pkg::PIN_END_STOP]
                           : pmx_pkg::IDLE_STOP;
    next_st.ready = ready_en ? pin_sync[pmx_pkg::PIN_READY]
                             : pmx_pkg::IDLE_READY;
    // A request only counts while its input is enabled
    next_st.request = request_en ? pin_sync[pmx_pkg::PIN_REQUEST]
                                 : pmx_pkg::IDLE_REQUEST;
    // Capture samples the wire even if the port drives it
    for (int i = 0; i < pmx_pkg::NUM_CAP; i++) begin
      next_st.capture[i] = capture_sel[i] ? pin_sync[pmx_pkg::CAP_BASE + i]
                                          : pmx_pkg::IDLE_CAPTURE;
    end
    if (st.age != 2'h3) begin
      next_st.age = st.age + 2'h1;
    end
    if (!nrst) begin
      next_st.port_in = '0;
      next_st.stop = pmx_pkg::IDLE_STOP;
      next_st.ready = pmx_pkg::IDLE_READY;
      next_st.request = pmx_pkg::IDLE_REQUEST;
      next_st.capture = {3{pmx_pkg::IDLE_CAPTURE}};
      next_st.age = 2'h0;
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign port_in = st.port_in;
  assign dma_stop_in_1 = st.stop;
  assign bus_ready_in = st.ready;
  assign bus_request_in = st.request;
  assign capture_input_0 = st.capture[0];
  assign capture_input_1 = st.capture[1];
  assign capture_input_2 = st.capture[2];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic live;  // Three clean cycles since reset, so all $past depths are valid
  assign live = (st.age == 2'h3);

  property p_ack_pin;
    @(posedge clk) disable iff (!nrst)
    live |-> pin_out[0] == ($past(ack_en) ? $past(dma_ack_out_1) : $past(port_out[0]));
  endproperty
  a_ack_pin: assert property (p_ack_pin) else $error("ack pin level wrong");

  property p_end_drive;
    @(posedge clk) disable iff (!nrst)
    live && $past(end_en) |-> pin_oe[1] && pin_out[1] == $past(dma_end_out_1);
  endproperty
  a_end_drive: assert property (p_end_drive) else $error("end output not driven");

  property p_stop_feed;
    @(posedge clk) disable iff (!nrst)
    live && $past(stop_en) |-> dma_stop_in_1 == $past(pin_in[1], 3);
  endproperty
  a_stop_feed: assert property (p_stop_feed) else $error("stop input not fed");

  property p_end_stop_port;
    @(posedge clk) disable iff (!nrst)
    live && !$past(end_en) && !$past(stop_en) |->
      pin_oe[1] == $past(port_dir[1]) && dma_stop_in_1 == pmx_pkg::IDLE_STOP;
  endproperty
  a_end_stop_port: assert property (p_end_stop_port) else $error("end/stop not port");

  property p_stop_only_release;
    @(posedge clk) disable iff (!nrst)
    live && !$past(end_en) && $past(stop_en) |-> !pin_oe[1];
  endproperty
  a_stop_only_release: assert property (p_stop_only_release)
    else $error("stop pin driven");

  property p_flyby;
    @(posedge clk) disable iff (!nrst)
    live |-> pin_out[2] == ($past(fly_wr_en) ? $past(flyby_write_strobe) : $past(port_out[2]))
          && pin_out[3] == ($past(fly_rd_en) ? $past(flyby_read_strobe) : $past(port_out[3]));
  endproperty
  a_flyby: assert property (p_flyby) else $error("fly-by strobe pin wrong");

  property p_bus_mode;
    @(posedge clk) disable iff (!nrst)
    live && $past(ext_bus_mode) |->
      pin_oe[4] && pin_oe[11] && pin_out[4] == $past(chip_sel_0)
      && pin_out[11] == $past(bus_read_strobe);
  endproperty
  a_bus_mode: assert property (p_bus_mode) else $error("bus mode pins wrong");

  property p_cs1_port;
    @(posedge clk) disable iff (!nrst)
    live && !$past(chip_sel_en[1]) |->
      pin_out[5] == $past(port_out[5]) && pin_oe[5] == $past(port_dir[5]);
  endproperty
  a_cs1_port: assert property (p_cs1_port) else $error("chip select 1 port wrong");

  property p_grant;
    @(posedge clk) disable iff (!nrst)
    live && $past(grant_en) |-> pin_oe[9] && (pin_out[9] == !$past(bus_released));
  endproperty
  a_grant: assert property (p_grant) else $error("grant pin wrong");

  property p_request;
    @(posedge clk) disable iff (!nrst)
    live |-> bus_request_in == ($past(request_en) && $past(pin_in[10], 3));
  endproperty
  a_request: assert property (p_request) else $error("request input wrong");

  property p_ready;
    @(posedge clk) disable iff (!nrst)
    live && !$past(ready_en) |-> bus_ready_in && (pin_oe[8] == $past(port_dir[8]));
  endproperty
  a_ready: assert property (p_ready) else $error("ready pin wrong");

  property p_capture;
    @(posedge clk) disable iff (!nrst)
    live && $past(capture_sel[1]) |-> capture_input_1 == $past(pin_in[9], 3);
  endproperty
  a_capture: assert property (p_capture) else $error("capture not sampled");

  // Chip select 3 is driven one cycle after its own enable is seen
  property p_cs3_drive;
    @(posedge clk) disable iff (!nrst)
    live && $past(chip_sel_en[3]) |-> pin_oe[7] && pin_out[7] == $past(chip_sel_3);
  endproperty
  a_cs3_drive: assert property (p_cs3_drive) else $error("chip select 3 not driven");

  // Single-chip mode hands chip select 0 and the read pin back to the port
  property p_chip_port;
    @(posedge clk) disable iff (!nrst)
    live && !$past(ext_bus_mode) |->
      pin_out[4] == $past(port_out[4]) && pin_oe[11] == $past(port_dir[11]);
  endproperty
  a_chip_port: assert property (p_chip_port) else $error("port pins wrong");

  // An unselected capture input must sit at idle, whatever the wire does
  property p_capture_idle;
    @(posedge clk) disable iff (!nrst)
    live && !$past(capture_sel[0]) |-> !capture_input_0;
  endproperty
  a_capture_idle: assert property (p_capture_idle) else $error("capture not idle");

  // Grant pin disabled: level and drive come from the port alone
  property p_grant_port;
    @(posedge clk) disable iff (!nrst)
    live && !$past(grant_en) |->
      pin_oe[9] == $past(port_dir[9]) && pin_out[9] == $past(port_out[9]);
  endproperty
  a_grant_port: assert property (p_grant_port) else $error("grant port wrong");

  c_ack_on: cover property (@(posedge clk) disable iff (!nrst) live && pin_oe[0] && $past(ack_en));
  c_stop_seen: cover property (@(posedge clk) disable iff (!nrst) $fell(dma_stop_in_1));
  c_grant_low: cover property (@(posedge clk) disable iff (!nrst) $past(grant_en) && !pin_out[9]);
  c_single_chip: cover property (@(posedge clk) disable iff (!nrst) live && !$past(ext_bus_mode));

endmodule : pmx_mux
`default_nettype wire

/* File: verilog/pmx_pkg.sv */
// Shared constants for the shared-pin multiplexer of the DMA and bus group
package pmx_pkg;

  // ----------------------------------------------------------------
  // Pin slots within the pin vectors
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 12;
  localparam int PIN_ACK = 0;        // Acceptance output / port_b_bit4
  localparam int PIN_END_STOP = 1;   // End output, stop input / port_b_bit5
  localparam int PIN_FLY_WR = 2;     // Fly-by write strobe / port_b_bit6
  localparam int PIN_FLY_RD = 3;     // Fly-by read strobe / port_b_bit7
  localparam int PIN_CS0 = 4;        // Chip select 0 / port_a_bit0
  localparam int PIN_CS1 = 5;        // Chip select 1 / port_a_bit1
  localparam int PIN_CS2 = 6;        // Chip select 2 / port_a_bit2
  localparam int PIN_CS3 = 7;        // Chip select 3 / port_a_bit3
  localparam int PIN_READY = 8;      // Ready input, capture 0 / port8_bit0
  localparam int PIN_GRANT = 9;      // Grant output, capture 1 / port8_bit1
  localparam int PIN_REQUEST = 10;   // Request input, capture 2 / port8_bit2
  localparam int PIN_READ = 11;      // Read strobe / port8_bit3
  localparam int CAP_BASE = 8;       // First pin that carries a capture input
  localparam int NUM_CAP = 3;

  // ----------------------------------------------------------------
  // Reset values and idle levels
  // ----------------------------------------------------------------
  localparam logic [11:0] RST_PIN_OUT = 12'h000;
  localparam logic [11:0] RST_PIN_OE = 12'h000;
  localparam logic RST_SYNC = 1'h0;
  localparam logic IDLE_STOP = 1'h1;     // Stop input is active low
  localparam logic IDLE_READY = 1'h1;    // Ready held high: no wait states
  localparam logic IDLE_REQUEST = 1'h0;  // Request is active high
  localparam logic IDLE_CAPTURE = 1'h0;
  localparam logic GRANT_ACTIVE = 1'h0;  // Grant pin is low while released

endpackage : pmx_pkg

/* File: verilog/pmx_sync.sv */
// Two-flop synchroniser for pin levels entering the clock domain
`timescale 1ns/10ps
`default_nettype none
module pmx_sync #(
  parameter int N = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Levels
  input wire logic [N-1:0] async_in,
  output logic [N-1:0] sync_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0] stage1;  // Read only by stage2
    logic [N-1:0] stage2;
  } pmx_sync_t;

  pmx_sync_t st;
  pmx_sync_t next_st;

  // Shift each bit one stage per clock
  always_comb begin
    next_st = st;
    for (int i = 0; i < N; i++) begin
      next_st.stage1[i] = async_in[i];
      next_st.stage2[i] = st.stage1[i];
    end
    if (!nrst) begin
      next_st.stage1 = {N{pmx_pkg::RST_SYNC}};
      next_st.stage2 = {N{pmx_pkg::RST_SYNC}};
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign sync_out = st.stage2;

endmodule : pmx_sync
`default_nettype wire
